// ===== design/terminal_load_control.sv
`timescale 1ns/1ps
module terminal_load_control
  import tlc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic word_valid_flag,
  input wire logic [WORD_W-1:0] word_in,
  output logic word_accept_flag,
  output logic [WORD_W-1:0] input_bus,
  output logic terminal_select_strobe,
  output logic counter_clear_line,
  output logic search_active,
  output logic bus_input_select,
  output logic unstagger_line,
  output logic restagger_line,
  output logic [MAX_BANKS-1:0] bank_enable,
  output logic [NB_W-1:0] current_bank_address,
  output logic busy
);
  logic [WORD_W-1:0] bus_reg;
  logic [NB_W-1:0] bank_count_reg;
  logic [NB_W-1:0] bank_address_reg;
  logic [NB_W-1:0] bank_address_next;
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [1:0] stag_cnt_reg;
  logic accept_reg;
  logic [4:0] opcode;
  logic [DA_W-1:0] relative_count;
  logic [NB_W-1:0] target_bank;
  logic all_banks;
  logic one_bank;
  logic bank_wrap;
  logic new_word;

  // ********************************************************************
  // Decoding helpers
  // ********************************************************************
  function automatic logic is_seek_op(input logic [4:0] op);
    is_seek_op = (op == OP_SEEK) || (op == OP_CLEAR_SUB) || (op == OP_END_ATTN)
      || (op == OP_MODIFY_IMAGE) || (op == OP_NEW_IMAGE);
  endfunction

  function automatic logic [MAX_BANKS-1:0] bank_mask(input logic [NB_W-1:0] n);
    logic [MAX_BANKS-1:0] m;
    m = '0;
    for (int i = 0; i < MAX_BANKS; i++) begin
      m[i] = (i <= int'(n));
    end
    bank_mask = m;
  endfunction

  assign opcode = bus_reg[OP_HI:OP_LO];
  assign relative_count = bus_reg[DA_LO +: DA_W];
  assign target_bank = (opcode == OP_END_ATTN) ? '0 : bus_reg[BA_LO +: NB_W];
  assign input_bus = bus_reg;
  assign current_bank_address = bank_address_reg;
  assign busy = (state_reg != ST_IDLE);
  assign word_accept_flag = accept_reg;
  assign bank_wrap = (bank_address_reg == bank_count_reg);

  // ********************************************************************
  // Word intake
  // ********************************************************************
  assign new_word = word_valid_flag && !accept_reg && (state_reg == ST_IDLE);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      accept_reg <= 1'b0;
    end else if (clk_en) begin
      accept_reg <= new_word;
    end
  end

  // Load word, or count the relative field down per whole layer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_reg <= '0;
    end else if (clk_en) begin
      if (new_word) begin
        bus_reg <= word_in;
      end else if (all_banks && state_reg == ST_LAYER && relative_count != '0) begin
        bus_reg[DA_LO +: DA_W] <= relative_count - 16'h0001;
      end
    end
  end

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept_reg) begin
          if (bus_reg[ATTN_BIT_HI] && bus_reg[ATTN_BIT_LO]) begin
            state_next = ST_SELECT;
          end else if (is_seek_op(opcode)) begin
            state_next = ST_PRESEEK;
          end else if (opcode == OP_WRITE_EDGE || opcode == OP_CLEAR_EDGE
                       || opcode == OP_SKIP_EDGE) begin
            state_next = ST_EDGE;
          end
        end
      end
      ST_SELECT: begin
        if (opcode == OP_NEW_IMAGE) begin
          state_next = ST_CLEARCNT;
        end else begin
          state_next = ST_PRESEEK;
        end
      end
      ST_CLEARCNT: state_next = ST_PRESEEK;
      ST_PRESEEK: begin
        if (relative_count == '0) begin
          state_next = ST_POSTSEEK;
        end else if (bank_address_reg == '0) begin
          state_next = ST_LAYER;
        end
      end
      ST_LAYER: begin
        if (relative_count == 16'h0001) begin
          state_next = ST_POSTSEEK;
        end
      end
      ST_POSTSEEK: begin
        if (bank_address_reg == target_bank) begin
          if (opcode == OP_MODIFY_IMAGE || opcode == OP_END_ATTN) begin
            state_next = ST_STAGGER;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_STAGGER: begin
        if (stag_cnt_reg == 2'(STAGGER_CYC - 1)) begin
          state_next = ST_IDLE;
        end
      end
      ST_EDGE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stag_cnt_reg <= 2'h0;
    end else if (clk_en) begin
      stag_cnt_reg <= (state_reg == ST_STAGGER) ? stag_cnt_reg + 2'h1 : 2'h0;
    end
  end

  // ********************************************************************
  // Bank enables
  // ********************************************************************
  // Whole-layer clocking while searching, then stagger first period
  assign all_banks = (state_reg == ST_LAYER) ||
    (state_reg == ST_STAGGER && stag_cnt_reg == 2'h0);
  // Single-bank steps for edge commands and before and after the layer run
  assign one_bank = (state_reg == ST_EDGE) ||
    (state_reg == ST_PRESEEK && relative_count != '0 && bank_address_reg != '0) ||
    (state_reg == ST_POSTSEEK && bank_address_reg != target_bank);

  always_comb begin
    bank_enable = '0;
    if (all_banks) begin
      bank_enable = bank_mask(bank_count_reg);
    end else if (one_bank) begin
      bank_enable[bank_address_reg] = 1'b1;
    end
  end

  always_comb begin
    bank_address_next = bank_address_reg;
    if (one_bank) begin
      bank_address_next = bank_wrap ? '0 : bank_address_reg + 4'h1;
    end else if (all_banks) begin
      bank_address_next = '0;
    end
  end

  // Attention zeroes the bank address and captures the count
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bank_count_reg <= BANK_COUNT_RST;
      bank_address_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == ST_IDLE && accept_reg && bus_reg[ATTN_BIT_HI] && bus_reg[ATTN_BIT_LO]) begin
        bank_count_reg <= bus_reg[NB_LO +: NB_W];
        bank_address_reg <= '0;
      end else begin
        bank_address_reg <= bank_address_next;
      end
    end
  end

  // ********************************************************************
  // Control lines
  // ********************************************************************
  assign terminal_select_strobe = (state_reg == ST_SELECT);
  assign counter_clear_line = (state_reg == ST_CLEARCNT);
  assign search_active = (state_reg == ST_LAYER);
  // Clear-sub-block writes nulls only while banks are clocked
  assign bus_input_select = bus_reg[WRITE_BIT] && busy &&
    ((opcode != OP_CLEAR_SUB) || (bank_enable != '0));
  assign unstagger_line = (state_reg == ST_STAGGER) && (opcode == OP_MODIFY_IMAGE);
  assign restagger_line = (state_reg == ST_STAGGER) && (opcode == OP_END_ATTN);

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_select_one_cycle: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(terminal_select_strobe) && clk_en |=> !terminal_select_strobe || !clk_en)
    else $error("select strobe longer than one period");
  a_clear_after_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(terminal_select_strobe) && opcode == OP_NEW_IMAGE |-> counter_clear_line)
    else $error("counter clear missing after select");
  a_bank_modulo: assert property (@(posedge core_clk) disable iff (sys_rst)
    bank_address_reg <= bank_count_reg || $past(accept_reg))
    else $error("bank address beyond bank count");
  a_stagger_banks: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(unstagger_line) |-> bank_enable == bank_mask(bank_count_reg))
    else $error("unstagger without all banks");
  a_restagger_len: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
    $rose(restagger_line) |=> restagger_line ##1 !restagger_line)
    else $error("restagger not two periods");
  a_wrap_on_last: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && bank_enable[bank_count_reg] && !accept_reg |=> bank_address_reg == '0)
    else $error("bank address not zero after last bank");
  a_no_accept_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
    busy && word_valid_flag |=> !word_accept_flag)
    else $error("word accepted while busy");
  a_write_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    search_active && opcode != OP_CLEAR_SUB |-> bus_input_select == bus_reg[WRITE_BIT])
    else $error("bus input select wrong");
endmodule // terminal_load_control

// ===== include/tlc_pkg.sv
package tlc_pkg;
  // ********************************************************************
  // Command word layout
  // ********************************************************************
  localparam int WORD_W = 80;
  localparam int OP_HI = 79;
  localparam int OP_LO = 75;
  localparam int ATTN_BIT_HI = 79;
  localparam int ATTN_BIT_LO = 77;
  localparam int WRITE_BIT = 78;
  localparam int NB_LO = 0;
  localparam int NB_W = 4;
  localparam int BA_LO = 4;
  localparam int DA_LO = 8;
  localparam int DA_W = 16;
  localparam int LA_LO = 24;
  localparam int LA_W = 11;
  localparam int TN_LO = 40;
  localparam int TN_W = 11;
  localparam int MAX_BANKS = 16;
  // ********************************************************************
  // Upper five bits of the command
  // ********************************************************************
  localparam logic [4:0] OP_NEW_IMAGE = 5'h1D;
  localparam logic [4:0] OP_MODIFY_IMAGE = 5'h15;
  localparam logic [4:0] OP_END_ATTN = 5'h17;
  localparam logic [4:0] OP_SEEK = 5'h01;
  localparam logic [4:0] OP_CLEAR_SUB = 5'h09;
  localparam logic [4:0] OP_WRITE_EDGE = 5'h0A;
  localparam logic [4:0] OP_CLEAR_EDGE = 5'h0B;
  localparam logic [4:0] OP_SKIP_EDGE = 5'h02;
  // ********************************************************************
  // Reset values and timing
  // ********************************************************************
  localparam logic [NB_W-1:0] BANK_COUNT_RST = 4'h0;
  localparam int TERM_PERIOD_NS = 134;
  localparam int CLK_PERIOD_NS = 50;
  // Terminal periods are modelled as one core cycle each
  localparam int TERM_PERIOD_CYC = 1;
  localparam int STAGGER_CYC = 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SELECT = 3'b001,
    ST_CLEARCNT = 3'b010,
    ST_PRESEEK = 3'b011,
    ST_LAYER = 3'b100,
    ST_POSTSEEK = 3'b101,
    ST_STAGGER = 3'b110,
    ST_EDGE = 3'b111
  } seq_state_t;
endpackage

// ===== tb/term_model.sv
`timescale 1ns/1ps
module term_model
  import tlc_pkg::*;
#(
  parameter logic [TN_W-1:0] NAME = 11'h005,
  parameter int NB = 3
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WORD_W-1:0] input_bus,
  input wire logic terminal_select_strobe,
  input wire logic counter_clear_line,
  input wire logic search_active,
  input wire logic restagger_line,
  input wire logic [MAX_BANKS-1:0] bank_enable,
  output logic load_mode_flag,
  output logic [LA_W-1:0] layer_address_register
);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      load_mode_flag <= 1'b0;
    end else if (terminal_select_strobe && input_bus[TN_LO +: TN_W] == NAME) begin
      load_mode_flag <= 1'b1;
    end else if (restagger_line && !bank_enable[NB]) begin
      load_mode_flag <= 1'b0;
    end
  end
  // Layer match only holds memory while searching
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      layer_address_register <= 11'h000;
    end else if (load_mode_flag && counter_clear_line) begin
      layer_address_register <= 11'h000;
    end else if (load_mode_flag && bank_enable[NB] && !(search_active
        && layer_address_register == input_bus[LA_LO +: LA_W])) begin
      layer_address_register <= layer_address_register + 11'h001;
    end
  end
endmodule // term_model

// ===== tb/test_terminal_load_control.sv
`timescale 1ns/1ps
module test_terminal_load_control
  import tlc_pkg::*;
;
  localparam logic [15:0] MSK = 16'h000F;
  localparam logic [10:0] BAD = 11'h7FF;
  logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, word_valid_flag = 1'b0;
  logic [WORD_W-1:0] word_in = 80'h0, input_bus, w;
  logic word_accept_flag, terminal_select_strobe, counter_clear_line, search_active;
  logic bus_input_select, unstagger_line, restagger_line, busy, t_load, o_load;
  logic [MAX_BANKS-1:0] bank_enable, be;
  logic [NB_W-1:0] current_bank_address;
  logic [LA_W-1:0] t_layer, l0;
  logic p_sel = 1'b0, p_st = 1'b0, clear_sub_block_cmd = 1'b0, sib;
  logic [4:0] ops [5] = '{OP_WRITE_EDGE, OP_CLEAR_EDGE, OP_WRITE_EDGE, OP_WRITE_EDGE, OP_SKIP_EDGE};
  int failures = 0, checks = 0, n_sel, n_clr, n_search_active, n_all, n_un, n_re;
  terminal_load_control terminal_load_control_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .word_valid_flag(word_valid_flag), .word_in(word_in),
    .word_accept_flag(word_accept_flag), .input_bus(input_bus),
    .terminal_select_strobe(terminal_select_strobe), .counter_clear_line(counter_clear_line),
    .search_active(search_active), .bus_input_select(bus_input_select),
    .unstagger_line(unstagger_line), .restagger_line(restagger_line),
    .bank_enable(bank_enable), .current_bank_address(current_bank_address), .busy(busy));
  term_model #(.NAME(11'h005), .NB(3)) term_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .input_bus(input_bus), .terminal_select_strobe(terminal_select_strobe),
    .counter_clear_line(counter_clear_line), .search_active(search_active),
    .restagger_line(restagger_line), .bank_enable(bank_enable),
    .load_mode_flag(t_load), .layer_address_register(t_layer));
  term_model #(.NAME(11'h006), .NB(3)) other_term_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .input_bus(input_bus), .terminal_select_strobe(terminal_select_strobe),
    .counter_clear_line(counter_clear_line), .search_active(search_active),
    .restagger_line(restagger_line), .bank_enable(bank_enable),
    .load_mode_flag(o_load), .layer_address_register());
  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [79:0] mk(logic [4:0] op, logic [10:0] la, logic [15:0] da,
      logic [3:0] ba, logic [3:0] nb);
    logic [79:0] v;
    v = 80'h0;
    v[OP_HI:OP_LO] = op;
    v[TN_LO +: TN_W] = 11'h005;
    v[LA_LO +: LA_W] = la;
    v[DA_LO +: DA_W] = da;
    v[BA_LO +: NB_W] = ba;
    v[NB_LO +: NB_W] = nb;
    return v;
  endfunction
  task automatic chk(string nm, logic [79:0] seen, logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic clr_cnt;
    {n_sel, n_clr, n_search_active, n_all, n_un, n_re} = '0;
    be = 16'h0;
    sib = 1'b0;
  endtask
  // Valid stays up through refusal while busy
  task automatic send(logic [79:0] v);
    int k;
    k = 0;
    @(posedge core_clk);
    word_in <= v;
    word_valid_flag <= 1'b1;
    @(posedge core_clk);
    #1;
    while (word_accept_flag !== 1'b1 && k < 400) begin
      k++;
      @(posedge core_clk);
      #1;
    end
    // Drop valid on the edge after accept is seen
    @(posedge core_clk);
    word_valid_flag <= 1'b0;
    if (k >= 400) begin failures++; conclude; end
  endtask
  task automatic idle;
    int k;
    k = 0;
    @(posedge core_clk);
    #1;
    while (busy !== 1'b0 && k < 1000) begin
      k++;
      @(posedge core_clk);
      #1;
    end
    if (k >= 1000) begin failures++; conclude; end
  endtask
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // ********************************************************************
  // Monitor, sampled mid-cycle
  // ********************************************************************
  always @(negedge core_clk) begin
    n_sel += terminal_select_strobe;
    n_search_active += search_active;
    if (search_active && (bank_enable & MSK) == MSK) n_all++;
    if (counter_clear_line) begin n_clr++; chk("clear_after_select", p_sel, 1'b1); end
    if ((unstagger_line | restagger_line) && !p_st) chk("stagger_all", bank_enable, MSK);
    n_un += unstagger_line;
    n_re += restagger_line;
    if (bank_enable != 16'h0) be = bank_enable;
    sib |= bus_input_select;
    if (clear_sub_block_cmd && busy) chk("csb_select", bus_input_select, |bank_enable);
    if (word_accept_flag) chk("accept_idle", busy, 1'b0);
    p_sel = terminal_select_strobe;
    p_st = unstagger_line | restagger_line;
  end
  // ********************************************************************
  // Scenarios
  // ********************************************************************
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("bus_reset", input_bus, 80'h0);
    clr_cnt;
    w = mk(OP_NEW_IMAGE, 11'h000, 16'h0000, 4'h0, 4'h3);
    send(w);
    idle;
    chk("bus", input_bus, w);
    chk("sel_cycles", n_sel, 1);
    chk("clr_cycles", n_clr, 1);
    chk("bank_zero", current_bank_address, 4'h0);
    chk("load_match", t_load, 1'b1);
    chk("load_other", o_load, 1'b0);
    l0 = t_layer;
    for (int i = 0; i < 5; i++) begin
      clr_cnt;
      send(mk(ops[i], 11'h000, 16'h0000, 4'h0, 4'h0));
      idle;
      chk("edge_enable", be, 16'h0001 << (i % 4));
      chk("edge_bus_sel", sib, i < 4);
      chk("bank_next", current_bank_address, (i + 1) % 4);
    end
    chk("layer_step", t_layer, l0 + 11'h001);
    @(posedge core_clk);
    clk_en <= 1'b0;
    word_in <= mk(OP_SKIP_EDGE, 11'h000, 16'h0000, 4'h0, 4'h0);
    word_valid_flag <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("freeze_accept", word_accept_flag, 1'b0);
    chk("freeze_bank", current_bank_address, 4'h1);
    @(posedge core_clk);
    word_valid_flag <= 1'b0;
    clk_en <= 1'b1;
    clr_cnt;
    l0 = t_layer;
    send(mk(OP_SEEK, BAD, 16'h0005, 4'h2, 4'h0));
    send(mk(OP_SKIP_EDGE, 11'h000, 16'h0000, 4'h0, 4'h0));
    idle;
    chk("seek_search", n_search_active, 5);
    chk("seek_layers", n_all, 5);
    chk("seek_bank", current_bank_address, 4'h3);
    chk("seek_layer", t_layer, l0 + 11'h006);
    clr_cnt;
    clear_sub_block_cmd = 1'b1;
    send(mk(OP_CLEAR_SUB, BAD, 16'h0003, 4'h3, 4'h0));
    idle;
    clear_sub_block_cmd = 1'b0;
    chk("csb_layers", n_all, 3);
    chk("csb_bank", current_bank_address, 4'h3);
    clr_cnt;
    send(mk(OP_MODIFY_IMAGE, BAD, 16'h0102, 4'h0, 4'h3));
    idle;
    chk("unstagger_len", n_un, 2);
    chk("modify_clear", n_clr, 0);
    chk("modify_bank", current_bank_address, 4'h0);
    clr_cnt;
    send(mk(OP_END_ATTN, BAD, 16'h0001, 4'h0, 4'h3));
    idle;
    chk("restagger_len", n_re, 2);
    chk("end_unstagger", n_un, 0);
    chk("end_bank", current_bank_address, 4'h0);
    chk("load_exit", t_load, 1'b0);
    conclude;
  end
endmodule // test_terminal_load_control
